// file: rtl/pgd_device.sv
// Display controller end: power-down mode control and pin parking
// Summary of operation
// - Internal-clock mode divides clocks by eight
// - General modes keep host I/O, memory access
// - Power-down blanks display; CRT mode kills DACs
// - External-clock mode: control bit7=1, select bit6=0
// - Internal-clock mode: both bits set
// - Low request enters selected mode automatically
// - General modes time refresh from interval field
// - Software preloads interval from clock, minus five
// - Refresh-per-line field gives one or two
// - Manager restores, settles clocks before release
// - Request high resumes normal, full-speed clocks
// - Low request plus bit5 isolates host interface
// - Manager raises request to end isolation
// - Sleep floats buses, parks strobes, pixel clock
// - Any power-down holds panel, color outputs low
// - Select bit7 chooses sleep over others
// - Both bit7 clear chooses display-idle
`timescale 1ns/1ps
module pgd_device #(
    parameter int DIV = pgd_pkg::PGD_CLK_DIV
) (
    input logic mclk_in,
    input logic rst_in,
    pgd_link_if.dev link,
    input logic reg_wr_in,
    input logic [1:0] reg_addr_in,
    input logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input logic crt_mode_in,
    input logic disp_refresh_in,
    output logic refresh_req_out,
    output logic int_clk_en_out,
    output logic host_io_en_out,
    output logic host_mem_en_out,
    output logic host_if_oe_out,
    output logic mem_data_oe_out,
    output logic strobes_high_out,
    output logic pixel_clock_low_out,
    output logic panel_low_out,
    output logic display_blank_out,
    output logic dac_off_out,
    output pgd_pkg::pgd_mode_e mode_out
);
    import pgd_pkg::*;

    // Refresh interval maths assumes the fixed divide ratio
    if (DIV != PGD_CLK_DIV) begin : g_div_check
        $error("pgd_device: only divide by eight is supported");
    end

    // Refresh cycles per line from the select field
    function automatic logic [1:0] refresh_count(input logic [1:0] sel);
        refresh_count = (sel == PGD_RPL_TWO) ? 2'h2 : 2'h1;
    endfunction

    // State and registers
    logic pd_meta_ff;
    logic pd_sync_ff;
    logic [7:0] prc_ff;
    logic [7:0] pms_ff;
    logic [1:0] rpl_ff;
    pgd_mode_e mode_ff;
    pgd_mode_e nxt_mode;
    logic [7:0] ivl_cnt_ff;
    logic [1:0] burst_ff;
    logic [7:0] rdata_ff;
    logic refresh_ff;
    logic clk_en_ff;
    logic io_en_ff;
    logic mem_en_ff;
    logic host_oe_ff;
    logic md_oe_ff;
    logic strobes_ff;
    logic pclk_low_ff;
    logic panel_low_ff;
    logic blank_ff;
    logic dac_off_ff;
    logic tick;

    // Two-stage synchroniser on the request pin
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pd_meta_ff <= 1'b1;
            pd_sync_ff <= 1'b1;
        end else begin
            pd_meta_ff <= link.power_down_request_n;
            pd_sync_ff <= pd_meta_ff;
        end
    end

    // Decoded request and mode selection
    wire pd_active = ~pd_sync_ff;
    wire sel_sleep = pms_ff[PGD_PMS_SLEEP_BIT];
    wire sel_gen = prc_ff[PGD_PRC_GEN_BIT];
    wire sel_int = pms_ff[PGD_PMS_INTCLK_BIT];
    wire isolated = pd_active & pms_ff[PGD_PMS_ISO_BIT];
    wire in_general = (mode_ff == PGD_GEN_EXT) || (mode_ff == PGD_GEN_INT);
    wire in_div8 = (mode_ff == PGD_GEN_INT) || (mode_ff == PGD_IDLE);

    // Mode is chosen at entry and held until the request rises
    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            PGD_NORMAL: begin
                if (pd_active) begin
                    if (sel_sleep) begin
                        nxt_mode = PGD_SLEEP;
                    end else if (!sel_gen) begin
                        nxt_mode = PGD_IDLE;
                    end else if (sel_int) begin
                        nxt_mode = PGD_GEN_INT;
                    end else begin
                        nxt_mode = PGD_GEN_EXT;
                    end
                end
            end
            PGD_GEN_EXT, PGD_GEN_INT, PGD_IDLE, PGD_SLEEP: begin
                if (!pd_active) begin
                    nxt_mode = PGD_NORMAL;
                end
            end
            default: nxt_mode = PGD_NORMAL;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            mode_ff <= PGD_NORMAL;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // Character-clock enable; realigned while in normal mode
    pgd_div #(
        .DIV(DIV)
    ) u_div (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .clear_in(mode_ff == PGD_NORMAL),
        .tick_out(tick)
    );

    // Host register access is refused while isolated or asleep
    wire host_refused = isolated || (mode_ff == PGD_SLEEP);
    wire wr_ok = reg_wr_in && !host_refused;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            prc_ff <= PGD_PRC_RST;
            pms_ff <= PGD_PMS_RST;
            rpl_ff <= PGD_RPL_RST;
        end else if (wr_ok) begin
            if (reg_addr_in == PGD_IDX_PRC) begin
                prc_ff <= reg_wdata_in;
            end
            if (reg_addr_in == PGD_IDX_PMS) begin
                pms_ff <= reg_wdata_in;
            end
            if (reg_addr_in == PGD_IDX_RPL) begin
                rpl_ff <= reg_wdata_in[1:0];
            end
        end
    end

    // Read data; refused reads return zero
    wire [7:0] rd_mux =
        host_refused ? 8'h00 :
        (reg_addr_in == PGD_IDX_PRC) ? prc_ff :
        (reg_addr_in == PGD_IDX_PMS) ? pms_ff :
        (reg_addr_in == PGD_IDX_RPL) ? {6'h00, rpl_ff} : 8'h00;

    // Refresh interval in character clocks: field plus five
    wire [7:0] ivl_len =
        {1'b0, prc_ff[PGD_PRC_IVL_MSB:0]} + PGD_IVL_OFFSET;
    wire ivl_done = (ivl_cnt_ff >= ivl_len - 8'h01);

    // Refresh timer replaces display timing during general modes.
    // Counts only on character ticks, so the rate tracks the clock.
    always_ff @(posedge mclk_in) begin
        if (rst_in || !in_general) begin
            ivl_cnt_ff <= 8'h00;
            burst_ff <= 2'h0;
        end else begin
            if (tick && ivl_done) begin
                ivl_cnt_ff <= 8'h00;
                burst_ff <= refresh_count(rpl_ff);
            end else begin
                if (tick) begin
                    ivl_cnt_ff <= ivl_cnt_ff + 8'h01;
                end
                if (burst_ff != 2'h0) begin
                    burst_ff <= burst_ff - 2'h1;
                end
            end
        end
    end

    // Refresh source: own timer in general modes, else display timing
    wire nxt_refresh = in_general ? (burst_ff != 2'h0) : disp_refresh_in;

    // Pin and access states per mode
    wire pd_mode = (mode_ff != PGD_NORMAL);
    wire sleep = (mode_ff == PGD_SLEEP);
    wire nxt_clk_en = in_div8 ? tick : 1'b1;
    wire nxt_io_en = !isolated && !sleep;
    wire nxt_mem_en = !isolated && !sleep &&
        (mode_ff != PGD_IDLE);
    wire nxt_host_oe = !isolated && !sleep;

    // Output flops
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_ff <= 8'h00;
            refresh_ff <= 1'b0;
            clk_en_ff <= 1'b1;
            io_en_ff <= 1'b1;
            mem_en_ff <= 1'b1;
            host_oe_ff <= 1'b1;
            md_oe_ff <= 1'b1;
            strobes_ff <= 1'b0;
            pclk_low_ff <= 1'b0;
            panel_low_ff <= 1'b0;
            blank_ff <= 1'b0;
            dac_off_ff <= 1'b0;
        end else begin
            rdata_ff <= rd_mux;
            refresh_ff <= nxt_refresh;
            clk_en_ff <= nxt_clk_en;
            io_en_ff <= nxt_io_en;
            mem_en_ff <= nxt_mem_en;
            host_oe_ff <= nxt_host_oe;
            md_oe_ff <= !sleep;
            strobes_ff <= sleep;
            pclk_low_ff <= sleep;
            panel_low_ff <= pd_mode;
            blank_ff <= pd_mode;
            dac_off_ff <= pd_mode && crt_mode_in;
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign refresh_req_out = refresh_ff;
    assign int_clk_en_out = clk_en_ff;
    assign host_io_en_out = io_en_ff;
    assign host_mem_en_out = mem_en_ff;
    assign host_if_oe_out = host_oe_ff;
    assign mem_data_oe_out = md_oe_ff;
    assign strobes_high_out = strobes_ff;
    assign pixel_clock_low_out = pclk_low_ff;
    assign panel_low_out = panel_low_ff;
    assign display_blank_out = blank_ff;
    assign dac_off_out = dac_off_ff;
    assign mode_out = mode_ff;
endmodule

// file: rtl/pgd_div.sv
// Divide-by-N clock enable generator
`timescale 1ns/1ps
module pgd_div #(
    parameter int DIV = 8
) (
    input logic mclk_in,
    input logic rst_in,
    input logic clear_in,
    output logic tick_out
);
    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_ff;
    logic tick_ff;
    wire at_last = (cnt_ff == LAST);

    // A single phase would never produce a gap between ticks
    if (DIV < 2) begin : g_div_check
        $error("pgd_div: DIV must be at least 2");
    end

    // Free-running count; clear realigns the enable phase
    always_ff @(posedge mclk_in) begin
        if (rst_in || clear_in) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= at_last ? '0 : cnt_ff + 1'b1;
            tick_ff <= at_last;
        end
    end

    assign tick_out = tick_ff;
endmodule

// file: rtl/pgd_link_if.sv
// Link between the display controller and the power manager
`timescale 1ns/1ps
interface pgd_link_if;
    logic power_down_request_n;
    logic clock_slow;
    // Display controller end
    modport dev (
        input power_down_request_n,
        input clock_slow
    );
    // Power manager end
    modport mgr (
        output power_down_request_n,
        output clock_slow
    );
endinterface

// file: rtl/pgd_manager.sv
// Power manager end: drives the request and the external clock speed
`timescale 1ns/1ps
module pgd_manager #(
    parameter int SETTLE_CYC = pgd_pkg::PGD_SETTLE_CYC
) (
    input logic mclk_in,
    input logic rst_in,
    pgd_link_if.mgr link,
    input logic sleep_req_in,
    input logic slow_clk_in,
    output logic pd_active_out
);
    import pgd_pkg::*;

    // Settle count must fit the 16-bit counter
    if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_settle_check
        $error("pgd_manager: SETTLE_CYC out of range");
    end

    localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYC - 1);

    pgd_mgr_e state_ff;
    pgd_mgr_e nxt_state;
    logic [15:0] cnt_ff;
    logic pd_n_ff;
    logic slow_ff;
    logic act_ff;

    // Clocks are restored and settle before the request is released
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            PGD_MGR_RUN: begin
                if (sleep_req_in) begin
                    nxt_state = PGD_MGR_DOWN;
                end
            end
            PGD_MGR_DOWN: begin
                if (!sleep_req_in) begin
                    nxt_state = PGD_MGR_RESTORE;
                end
            end
            PGD_MGR_RESTORE: begin
                if (cnt_ff == SETTLE_LAST) begin
                    nxt_state = PGD_MGR_RUN;
                end
            end
            default: nxt_state = PGD_MGR_RUN;
        endcase
    end

    // Settle counter runs only while restoring
    always_ff @(posedge mclk_in) begin
        if (rst_in || state_ff != PGD_MGR_RESTORE) begin
            cnt_ff <= 16'h0000;
        end else begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    // Slow clocks only after the request is down; request low till run
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_ff <= PGD_MGR_RUN;
            pd_n_ff <= 1'b1;
            slow_ff <= 1'b0;
            act_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pd_n_ff <= (nxt_state == PGD_MGR_RUN);
            act_ff <= (nxt_state != PGD_MGR_RUN);
            slow_ff <= (nxt_state == PGD_MGR_DOWN) &&
                (state_ff == PGD_MGR_DOWN) && slow_clk_in;
        end
    end

    assign link.power_down_request_n = pd_n_ff;
    assign link.clock_slow = slow_ff;
    assign pd_active_out = act_ff;
endmodule

// file: rtl/pgd_pkg.sv
// Shared constants and types for the general power-down control block
package pgd_pkg;
    // Register indices on the device's register port
    localparam logic [1:0] PGD_IDX_PRC = 2'h0;
    localparam logic [1:0] PGD_IDX_PMS = 2'h1;
    localparam logic [1:0] PGD_IDX_RPL = 2'h2;
    // Reset values
    localparam logic [7:0] PGD_PRC_RST = 8'h00;
    localparam logic [7:0] PGD_PMS_RST = 8'h00;
    localparam logic [1:0] PGD_RPL_RST = 2'h1;
    // Field positions
    localparam int PGD_PRC_GEN_BIT = 7;
    localparam int PGD_PRC_IVL_MSB = 6;
    localparam int PGD_PMS_SLEEP_BIT = 7;
    localparam int PGD_PMS_INTCLK_BIT = 6;
    localparam int PGD_PMS_ISO_BIT = 5;
    // Refresh interval offset and refresh-per-line encodings
    localparam logic [7:0] PGD_IVL_OFFSET = 8'h05;
    localparam logic [1:0] PGD_RPL_TWO = 2'h3;
    localparam logic [1:0] PGD_RPL_ONE = 2'h1;
    // Internal clock divide ratio
    localparam int PGD_CLK_DIV = 8;
    // Timing: clock period and manager's clock settle time
    localparam int PGD_CLK_PERIOD_NS = 40;
    localparam int PGD_SETTLE_NS = 10000;
    localparam int PGD_SETTLE_CYC =
        (PGD_SETTLE_NS + PGD_CLK_PERIOD_NS - 1) / PGD_CLK_PERIOD_NS;
    // Power modes, Gray coded along the usual path
    typedef enum logic [2:0] {
        PGD_NORMAL  = 3'h0,
        PGD_GEN_EXT = 3'h1,
        PGD_GEN_INT = 3'h3,
        PGD_IDLE    = 3'h2,
        PGD_SLEEP   = 3'h6
    } pgd_mode_e;
    // Power manager states
    typedef enum logic [1:0] {
        PGD_MGR_RUN     = 2'h0,
        PGD_MGR_DOWN    = 2'h1,
        PGD_MGR_RESTORE = 2'h3
    } pgd_mgr_e;
endpackage

// file: test/pgd_link_assertions.sv
// Checker on the power-down link and the device's mode outputs
`timescale 1ns/1ps
module pgd_link_assertions
    import pgd_pkg::*;
#(
    parameter int SETTLE_CYC = PGD_SETTLE_CYC
) (
    input logic mclk_in,
    input logic rst_in,
    input logic power_down_request_n,
    input logic clock_slow,
    input pgd_pkg::pgd_mode_e mode_out,
    input logic panel_low_out,
    input logic display_blank_out,
    input logic strobes_high_out,
    input logic host_if_oe_out,
    input logic int_clk_en_out
);
    // One clock domain, so one clocking and one disable
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    a_enter_on_low: assert property (
        $fell(power_down_request_n) |-> ##3 mode_out != PGD_NORMAL)
        else $error("mode not entered three edges after request");
    a_exit_on_high: assert property (
        $rose(power_down_request_n) |-> ##3 mode_out == PGD_NORMAL)
        else $error("mode not normal three edges after release");
    a_mode_held: assert property (
        (mode_out != PGD_NORMAL) ##1 (mode_out != PGD_NORMAL)
        |-> $stable(mode_out))
        else $error("mode changed while powered down");
    a_panel_parked: assert property (
        (mode_out != PGD_NORMAL) ##1 (mode_out != PGD_NORMAL)
        |-> panel_low_out && display_blank_out)
        else $error("panel not parked low or display not blanked");
    a_sleep_parked: assert property (
        (mode_out == PGD_SLEEP) ##1 (mode_out == PGD_SLEEP)
        |-> strobes_high_out && !host_if_oe_out)
        else $error("sleep pin states wrong");
    a_div_eight: assert property (
        (int_clk_en_out && mode_out == PGD_GEN_INT)
        |=> (!int_clk_en_out || mode_out != PGD_GEN_INT) [*7])
        else $error("internal clock enable faster than one in eight");
    a_ext_full: assert property (
        (mode_out == PGD_GEN_EXT) [*2] |-> int_clk_en_out)
        else $error("clock divided in external clock mode");
    a_slow_while_down: assert property (
        clock_slow |-> !power_down_request_n)
        else $error("clock slowed while request released");
    a_settle_first: assert property (
        $rose(power_down_request_n) |-> !$past(clock_slow, SETTLE_CYC))
        else $error("request released before clock settled");
endmodule

// file: test/tb_general_power_down_control.sv
// Self-checking bench for both ends of the power-down link
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; \
    if ((got) !== (exp)) begin errors++; \
    $display("ERROR %s exp %0h got %0h", nm, exp, got); end end
module tb_general_power_down_control;
    import pgd_pkg::*;
    localparam int SETTLE = 4;
    logic mclk_in, rst_in, reg_wr, crt, disp_ref, sleep, slow;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic refresh, clk_en, io_en, mem_en, if_oe, md_oe, strb, pclk, panel;
    logic blank, dac, pd_active, prev;
    pgd_mode_e mode;
    int errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int t0, t1;

    pgd_link_if link ();
    pgd_device pgd_device_inst (.mclk_in(mclk_in), .rst_in(rst_in),
        .link(link.dev), .reg_wr_in(reg_wr), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
        .crt_mode_in(crt), .disp_refresh_in(disp_ref),
        .refresh_req_out(refresh), .int_clk_en_out(clk_en),
        .host_io_en_out(io_en), .host_mem_en_out(mem_en),
        .host_if_oe_out(if_oe), .mem_data_oe_out(md_oe),
        .strobes_high_out(strb), .pixel_clock_low_out(pclk),
        .panel_low_out(panel), .display_blank_out(blank),
        .dac_off_out(dac), .mode_out(mode));
    pgd_manager #(.SETTLE_CYC(SETTLE)) pgd_manager_inst (.mclk_in(mclk_in),
        .rst_in(rst_in), .link(link.mgr), .sleep_req_in(sleep),
        .slow_clk_in(slow), .pd_active_out(pd_active));
    pgd_link_assertions #(.SETTLE_CYC(SETTLE)) pgd_link_assertions_inst (
        .mclk_in(mclk_in), .rst_in(rst_in),
        .power_down_request_n(link.power_down_request_n),
        .clock_slow(link.clock_slow), .mode_out(mode),
        .panel_low_out(panel), .display_blank_out(blank),
        .strobes_high_out(strb), .host_if_oe_out(if_oe),
        .int_clk_en_out(clk_en));

    // Free-running clock and a cycle count for interval checks
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) cyc <= cyc + 1;

    // Verdict and end of run, also reached on a timeout
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Register port: write strobe for one cycle, read one edge later
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk_in);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(negedge mclk_in);
        reg_addr = a;
        @(negedge mclk_in);
        `CHK("rdata", e, reg_rdata)
    endtask

    // Mode and parked pin states as one vector
    task automatic pins(input logic [11:0] e);
        `CHK("pins", e, {mode, blank, panel, dac, io_en, mem_en, if_oe,
            md_oe, strb, pclk})
    endtask

    // Request through the manager; pins settle five edges later
    task automatic down(input logic s);
        @(negedge mclk_in);
        slow = s;
        sleep = 1'b1;
        repeat (6) @(negedge mclk_in);
    endtask
    task automatic up();
        int i;
        sleep = 1'b0;
        for (i = 0; i < SETTLE + 30; i++) begin
            @(negedge mclk_in);
            if (mode === PGD_NORMAL) break;
        end
        if (i == SETTLE + 30) begin
            errors++;
            $display("ERROR exit wait timed out");
            give_verdict();
        end
        repeat (2) @(negedge mclk_in);
    endtask

    // Time of the first pulse of the next refresh burst
    task automatic wait_ref(output int t);
        int i;
        prev = 1'b1;
        for (i = 0; i < 400; i++) begin
            @(negedge mclk_in);
            if (refresh === 1'b1 && prev === 1'b0) break;
            prev = refresh;
        end
        if (i == 400) begin
            errors++;
            $display("ERROR refresh wait timed out");
            give_verdict();
        end
        t = cyc;
    endtask

    initial begin
        {reg_wr, crt, disp_ref, sleep, slow} = 5'h08;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        rst_in = 1'b1;
        repeat (3) @(negedge mclk_in);
        rst_in = 1'b0;
        // Reset values and the unused index
        rd(PGD_IDX_PRC, PGD_PRC_RST);
        rd(PGD_IDX_PMS, PGD_PMS_RST);
        rd(PGD_IDX_RPL, PGD_RPL_RST);
        rd(2'h3, 8'h00);
        pins(12'h03C);
        // Normal mode passes the display timing refresh through
        disp_ref = 1'b1;
        @(negedge mclk_in);
        `CHK("pass_refresh", 1'b1, refresh)
        disp_ref = 1'b0;
        $display("test reset done");
        // External clock mode, one refresh per line, field 1
        wr(PGD_IDX_PRC, 8'h81);
        down(1'b1);
        pins(12'h3FC);
        `CHK("pd_active", 1'b1, pd_active)
        `CHK("clock_slow", 1'b1, link.clock_slow)
        wr(PGD_IDX_PMS, 8'h01);
        rd(PGD_IDX_PMS, 8'h01);
        wr(PGD_IDX_PMS, 8'h00);
        pins(12'h3FC);
        // Display timing refresh must be ignored in the general modes
        disp_ref = 1'b1;
        wait_ref(t0);
        @(negedge mclk_in);
        `CHK("single", 1'b0, refresh)
        wait_ref(t1);
        `CHK("interval", 48, t1 - t0)
        disp_ref = 1'b0;
        up();
        pins(12'h03C);
        `CHK("pd_active", 1'b0, pd_active)
        `CHK("clock_slow", 1'b0, link.clock_slow)
        $display("test external clock done");
        // Internal clock mode, two refreshes per line, field 2
        crt = 1'b0;
        wr(PGD_IDX_PRC, 8'h82);
        wr(PGD_IDX_PMS, 8'h40);
        wr(PGD_IDX_RPL, PGD_RPL_TWO);
        down(1'b0);
        pins(12'h7BC);
        wait_ref(t0);
        @(negedge mclk_in);
        `CHK("burst", 1'b1, refresh)
        wait_ref(t1);
        `CHK("interval", 56, t1 - t0)
        up();
        `CHK("clk_en", 1'b1, clk_en)
        $display("test internal clock done");
        // Idle mode with host isolation; writes refused
        crt = 1'b1;
        wr(PGD_IDX_PRC, 8'h00);
        wr(PGD_IDX_PMS, 8'h20);
        down(1'b0);
        pins(12'h5C4);
        wr(PGD_IDX_PRC, 8'hFF);
        rd(PGD_IDX_PMS, 8'h00);
        up();
        rd(PGD_IDX_PRC, 8'h00);
        pins(12'h03C);
        $display("test isolation done");
        // Sleep wins over the general bits
        wr(PGD_IDX_PRC, 8'h80);
        wr(PGD_IDX_PMS, 8'hC0);
        down(1'b0);
        pins(12'hDC3);
        up();
        pins(12'h03C);
        $display("test sleep done");
        give_verdict();
    end
endmodule
